// ---- sim/eipm_cpu_model.sv ----
// Purpose: CPU core stand-in that retires instructions
// Assumes: Core makes no progress while its clock is gated
// Notes:   Slow mode stretches each instruction to four cycles
`timescale 1ns/100ps
module eipm_cpu_model (
	input  wire logic clock,
	input  wire logic reset_n,
	input  wire logic cpu_clk_en,
	input  wire logic slow,
	output logic      instr_done
);
	logic [2:0] cnt;
	// Two cycles each, four in slow mode: an idle write is always followed by a two-byte opcode
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n)
			cnt <= 3'h0;
		else if (cpu_clk_en)
			cnt <= (cnt >= (slow ? 3'h3 : 3'h1)) ? 3'h0 : cnt + 3'h1;
	end
	assign instr_done = cpu_clk_en && cnt == 3'h0;
endmodule

// ---- sim/tb_eipm_top.sv ----
// Purpose: Self-checking bench for irq config and power modes
// Assumes: APB with one wait state; answer taken at the pready edge
// Notes:   Clock-loss count runs at its full length
`timescale 1ns/100ps
`include "eipm_consts.svh"
module tb_eipm_top;
	import eipm_pkg::*;
	localparam logic [9:0] A_PWR = `EIPM_ADDR(`EIPM_IDX_PWR);
	localparam logic [9:0] A_CFG = `EIPM_ADDR(`EIPM_IDX_EXTCFG);
	localparam logic [9:0] A_PRI = `EIPM_ADDR(`EIPM_IDX_PRIO);
	localparam logic [9:0] A_STA = `EIPM_ADDR(`EIPM_IDX_STATUS);
	localparam logic [9:0] A_CTL = `EIPM_ADDR(`EIPM_IDX_CTRL);
	logic          clock, reset_n, done, gie, wdt_req, ext_req, lost, slow, err;
	logic          irq0, irq1, cpu_en, per_en, osc_en, wdt_run, sys_rst;
	eipm_apb_req_s req;
	eipm_apb_rsp_s rsp;
	logic [7:0]    pins, xreq, xok, rd, cfg;
	logic [10:0]   pend, mask;
	logic [5:0]    prio;
	logic [15:0]   pc;
	logic [2:0]    s;
	int            fails, total_checks, n;
	eipm_top eipm_top_i (
		.CLOCK(clock), .RESET_N(reset_n), .APB_REQ(req), .APB_RSP(rsp),
		.PORT_PIN(pins), .XBAR_ROUTE_REQ(xreq), .XBAR_ROUTE_OK(xok),
		.INSTR_DONE(done), .GLOBAL_IRQ_ENABLE(gie), .IRQ_PENDING(pend),
		.IRQ_MASK(mask), .WDT_RESET_REQ(wdt_req), .EXT_RESET_REQ(ext_req),
		.OSC_CLOCK_LOST(lost), .EXTERNAL_IRQ_0(irq0), .EXTERNAL_IRQ_1(irq1),
		.EXT_PRIORITY(prio), .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(per_en),
		.INT_OSC_EN(osc_en), .WDT_RUN(wdt_run), .SYS_RESET(sys_rst),
		.RESTART_PC(pc));
	eipm_cpu_model eipm_cpu_model_i (.clock(clock), .reset_n(reset_n),
		.cpu_clk_en(cpu_en), .slow(slow), .instr_done(done));
	// ==========================================================
	// Bus and compare helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d);
		logic got;
		@(posedge clock);
		req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: wr, pwdata: d};
		@(posedge clock);
		req.penable <= 1'b1;
		got = 1'b0;
		// Mid-cycle values are what the next rising edge samples
		while (got !== 1'b1) begin
			@(negedge clock);
			got = rsp.pready;
			rd = rsp.prdata[7:0];
			err = rsp.pslverr;
			@(posedge clock);
		end
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [9:0] a, input logic [7:0] e);
		apb(1'b0, a, 32'h0);
		check(rd, e);
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clock);
		#1;
	endtask
	task automatic wait_cpu(input logic v);
		repeat (20) if (cpu_en !== v) tick(1);
		check(cpu_en, v);
	endtask
	task automatic wait_rst;
		n = 0;
		while (sys_rst !== 1'b1 && n < 6000) begin
			tick(1);
			n++;
		end
	endtask
	task automatic give_verdict;
		$display("checks=%0d fails=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// ==========================================================
	// Clock, watchdog and tests
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	initial begin
		#1_000_000;
		fails++;
		give_verdict();
	end
	initial begin
		{fails, total_checks, reset_n, gie, wdt_req, ext_req, lost, slow} = '0;
		{req, pins, xreq, pend, mask} = '0;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		rdchk(A_PWR, 8'h00);
		rdchk(A_CFG, 8'h01);
		rdchk(A_PRI, 8'hC0);
		apb(1'b0, 10'h000, 32'h0);
		check(err, 1'b1);
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, A_PRI, i ? 32'h15 : 32'hEA);
			rdchk(A_PRI, i ? 8'hD5 : 8'hEA);
			check(prio, i ? 6'h15 : 6'h2A);
		end
		$display("test priority done");
		apb(1'b1, A_CTL, 32'h2F0);
		xreq <= 8'hFF;
		for (int i = 0; i < 16; i++) begin
			s = i[2:0];
			cfg = {i[3], s, ~i[3], ~s};
			apb(1'b1, A_CFG, {24'h0, cfg});
			pins <= 8'h01 << s;
			tick(3);
			check(irq1, i[3]);
			check(irq0, i[3]);
			check(xok, 8'h0F);
		end
		$display("test pin select done");
		apb(1'b1, A_PWR, 32'hA9);
		wait_cpu(1'b0);
		check(per_en, 1'b1);
		check(wdt_run, 1'b1);
		rdchk(A_PWR, 8'hA8);
		rdchk(A_CFG, cfg);
		pend <= 11'h400;
		gie <= 1'b1;
		tick(6);
		check(cpu_en, 1'b0);
		mask <= 11'h400;
		wait_cpu(1'b1);
		rdchk(A_STA, 8'h00);
		$display("test idle wake done");
		{pend, mask} <= '0;
		apb(1'b1, A_PWR, 32'h01);
		wait_cpu(1'b0);
		wdt_req <= 1'b1;
		wait_rst();
		check(sys_rst, 1'b1);
		check(pc, 16'h0000);
		wdt_req <= 1'b0;
		rdchk(A_STA, 8'h00);
		rdchk(A_PWR, 8'h00);
		$display("test idle reset done");
		slow <= 1'b1;
		apb(1'b1, A_PWR, 32'h02);
		wait_cpu(1'b0);
		check(osc_en, 1'b0);
		check(per_en, 1'b0);
		{pend, mask} <= {11'h001, 11'h001};
		tick(10);
		check(cpu_en, 1'b0);
		ext_req <= 1'b1;
		wait_rst();
		check(pc, 16'h0000);
		ext_req <= 1'b0;
		wait_cpu(1'b1);
		$display("test stop done");
		{pend, mask} <= '0;
		apb(1'b1, A_CTL, 32'h3F0);
		apb(1'b1, A_PWR, 32'h02);
		lost <= 1'b1;
		wait_rst();
		check(n >= 4995 && n <= 5005, 1'b1);
		lost <= 1'b0;
		$display("test clock loss done");
		give_verdict();
	end
endmodule

// ---- src/eipm_consts.svh ----
// Purpose: Named constants for the interrupt config and power mode block
// Assumes: APB byte addresses are four times the printed register index
// Notes:   Included by the package and the top module
`ifndef EIPM_CONSTS_SVH
`define EIPM_CONSTS_SVH
// ==========================================================
// Register indices and byte addresses
`define EIPM_IDX_PWR        8'h87
`define EIPM_IDX_EXTCFG     8'hE4
`define EIPM_IDX_PRIO       8'hF6
`define EIPM_IDX_STATUS     8'hF0
`define EIPM_IDX_CTRL       8'hF1
`define EIPM_ADDR_W         10
`define EIPM_ADDR(i)        {i, 2'b00}
// ==========================================================
// Reset values and field masks
`define EIPM_RST_PWR        8'h00
`define EIPM_RST_EXTCFG     8'h01
`define EIPM_RST_PRIO       8'hC0
`define EIPM_PRIO_FIXED     8'hC0
`define EIPM_PRIO_WMASK     8'h3F
`define EIPM_PWR_FLAGMASK   8'hFC
`define EIPM_BIT_IDLE       0
`define EIPM_BIT_STOP       1
`define EIPM_BIT_E1POL      7
`define EIPM_BIT_E0POL      3
`define EIPM_RESTART_PC     16'h0000
// ==========================================================
// Timing: clock-loss timeout
`define EIPM_CLK_MHZ        50
`define EIPM_MCD_US         100
`define EIPM_MCD_CYC        (`EIPM_MCD_US * `EIPM_CLK_MHZ)
`endif

// ---- src/eipm_pkg.sv ----
// Purpose: Types for the interrupt config and power mode block
// Assumes: Constants come from the consts header
// Notes:   State is carried as one packed struct
`include "eipm_consts.svh"
package eipm_pkg;
	typedef enum logic [1:0] {
		EIPM_RUN  = 2'b00,
		EIPM_IDLE = 2'b01,
		EIPM_STOP = 2'b10
	} eipm_mode_e;

	typedef struct packed {
		logic [`EIPM_ADDR_W-1:0] paddr;
		logic                    psel;
		logic                    penable;
		logic                    pwrite;
		logic [31:0]             pwdata;
	} eipm_apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} eipm_apb_rsp_s;

	typedef struct packed {
		eipm_mode_e  mode;
		logic [7:0]  pwr_flags;
		logic [7:0]  extcfg;
		logic [5:0]  prio;
		logic [7:0]  skip;
		logic        mcd_en;
		logic        wdt_en;
		logic [31:0] mcd_cnt;
		logic [31:0] prdata;
		logic        pslverr;
		logic        ext0;
		logic        ext1;
		logic        cpu_gate;
		logic        sys_reset;
		logic        ack;
	} eipm_state_s;
endpackage

// ---- src/eipm_top.sv ----
// Purpose: Extended priority, external irq pin config and idle/stop control
// Assumes: Pin, irq and CPU signals are synchronous to CLOCK
// Notes:   Mode reset here stands for the device reset sequence request
`timescale 1ns/100ps
`include "eipm_consts.svh"
// Contract
// - Priority bits 7:6 always read one, writes to them ignored
// - Priority bits 5:0 give low/high level per extended source
// - Config bit 7 sets second external input polarity
// - Config bits 6:4 pick port-zero pin for second external input
// - Config bit 3 first input polarity, bits 2:0 its pin
// - External inputs sample pins without altering crossbar routing
// - Crossbar never routes a peripheral onto a skipped pin
// - Idle bit write halts CPU after instruction; peripherals keep running
// - Registers and memory keep their contents during idle
// - Enabled interrupt clears idle, resumes CPU to service it
// - Reset during idle runs normal reset from address zero
// - Enabled watchdog keeps counting in idle and may reset
// - Stop bit write halts oscillator, CPU and digital peripherals
// - Stop ends only by reset, never by an interrupt
// - Clock-loss detector runs in stop, resets after 100 us
// - Stop and idle bits always read zero
// - Power bits 7:2 are plain software flags
// - Interrupt enabled only with global enable and its mask set
module eipm_top (
	input  wire logic                   CLOCK,
	input  wire logic                   RESET_N,
	input  wire eipm_pkg::eipm_apb_req_s APB_REQ,
	output eipm_pkg::eipm_apb_rsp_s      APB_RSP,
	input  wire logic [7:0]             PORT_PIN,
	input  wire logic [7:0]             XBAR_ROUTE_REQ,
	output logic [7:0]                  XBAR_ROUTE_OK,
	input  wire logic                   INSTR_DONE,
	input  wire logic                   GLOBAL_IRQ_ENABLE,
	input  wire logic [10:0]            IRQ_PENDING,
	input  wire logic [10:0]            IRQ_MASK,
	input  wire logic                   WDT_RESET_REQ,
	input  wire logic                   EXT_RESET_REQ,
	input  wire logic                   OSC_CLOCK_LOST,
	output logic                        EXTERNAL_IRQ_0,
	output logic                        EXTERNAL_IRQ_1,
	output logic [5:0]                  EXT_PRIORITY,
	output logic                        CPU_CLK_EN,
	output logic                        PERIPH_CLK_EN,
	output logic                        INT_OSC_EN,
	output logic                        WDT_RUN,
	output logic                        SYS_RESET,
	output logic [15:0]                 RESTART_PC
);
	import eipm_pkg::*;

	eipm_state_s s;
	eipm_state_s next_s;
	logic        wr;
	logic        rd;
	logic        acc;
	logic        irq_wake;
	logic        rst_req;
	logic [`EIPM_ADDR_W-1:0] a;

	assign a = APB_REQ.paddr;
	// One wait state: registered read data must already stand when pready is high
	assign acc = APB_REQ.psel & APB_REQ.penable;
	assign wr = acc & APB_REQ.pwrite & s.ack;
	assign rd = acc & ~APB_REQ.pwrite & ~s.ack;
	// Wake only on a source both masked in and globally enabled
	assign irq_wake = GLOBAL_IRQ_ENABLE & |(IRQ_PENDING & IRQ_MASK);
	// ======================================================
	// Reset requests: watchdog, external, clock loss
	assign rst_req = WDT_RESET_REQ | EXT_RESET_REQ
		| (s.mcd_en & (s.mcd_cnt >= 32'(`EIPM_MCD_CYC)));

	always_comb begin
		next_s = s;
		next_s.pslverr = 1'b0;
		next_s.prdata = 32'h0;
		next_s.sys_reset = 1'b0;
		next_s.ack = acc & ~s.ack;
		// ==================================================
		// Register writes
		if (wr) begin
			unique case (a)
				`EIPM_ADDR(`EIPM_IDX_PWR): begin
					next_s.pwr_flags = APB_REQ.pwdata[7:0] & `EIPM_PWR_FLAGMASK;
					// Only a reset leaves stop, so mode writes are ignored there
					if (s.mode != EIPM_STOP) begin
						if (APB_REQ.pwdata[`EIPM_BIT_STOP]) begin
							next_s.mode = EIPM_STOP;
						end else if (APB_REQ.pwdata[`EIPM_BIT_IDLE]) begin
							next_s.mode = EIPM_IDLE;
						end
					end
				end
				`EIPM_ADDR(`EIPM_IDX_EXTCFG): next_s.extcfg = APB_REQ.pwdata[7:0];
				`EIPM_ADDR(`EIPM_IDX_PRIO):   next_s.prio = APB_REQ.pwdata[5:0];
				`EIPM_ADDR(`EIPM_IDX_CTRL): begin
					next_s.skip = APB_REQ.pwdata[7:0];
					next_s.mcd_en = APB_REQ.pwdata[8];
					next_s.wdt_en = APB_REQ.pwdata[9];
				end
				default: ;
			endcase
		end
		// Decode errors flagged on the first access cycle so they stand with pready
		if (acc & ~s.ack) begin
			unique case (a)
				`EIPM_ADDR(`EIPM_IDX_PWR):    next_s.pslverr = 1'b0;
				`EIPM_ADDR(`EIPM_IDX_EXTCFG): next_s.pslverr = 1'b0;
				`EIPM_ADDR(`EIPM_IDX_PRIO):   next_s.pslverr = 1'b0;
				`EIPM_ADDR(`EIPM_IDX_CTRL):   next_s.pslverr = 1'b0;
				`EIPM_ADDR(`EIPM_IDX_STATUS): next_s.pslverr = APB_REQ.pwrite;
				default:                      next_s.pslverr = 1'b1;
			endcase
		end
		// ==================================================
		// Register reads
		if (rd) begin
			unique case (a)
				`EIPM_ADDR(`EIPM_IDX_PWR):    next_s.prdata = {24'h0, s.pwr_flags};
				`EIPM_ADDR(`EIPM_IDX_EXTCFG): next_s.prdata = {24'h0, s.extcfg};
				`EIPM_ADDR(`EIPM_IDX_PRIO):
					next_s.prdata = {24'h0, `EIPM_PRIO_FIXED | {2'b00, s.prio}};
				`EIPM_ADDR(`EIPM_IDX_STATUS): next_s.prdata = {30'h0, s.mode};
				`EIPM_ADDR(`EIPM_IDX_CTRL):
					next_s.prdata = {22'h0, s.wdt_en, s.mcd_en, s.skip};
				default: next_s.pslverr = 1'b1;
			endcase
		end
		// ==================================================
		// Power mode sequencing
		unique case (s.mode)
			EIPM_RUN: next_s.cpu_gate = 1'b1;
			EIPM_IDLE: begin
				// Gate only once the setting instruction has retired
				if (INSTR_DONE) begin
					next_s.cpu_gate = 1'b0;
				end
				if (irq_wake) begin
					next_s.mode = EIPM_RUN;
					next_s.cpu_gate = 1'b1;
				end
			end
			EIPM_STOP: begin
				// Interrupts ignored here; only a reset leaves stop
				if (INSTR_DONE) begin
					next_s.cpu_gate = 1'b0;
				end
			end
			default: next_s.mode = EIPM_RUN;
		endcase
		// Clock-loss counter counts while enabled and the clock is lost, stop included; restarts from zero after firing
		if (s.mcd_en & OSC_CLOCK_LOST) begin
			next_s.mcd_cnt = s.mcd_cnt + 32'h1;
		end else begin
			next_s.mcd_cnt = 32'h0;
		end
		if (rst_req) begin
			// Normal reset sequence; data memory lives outside this block
			next_s.mode = EIPM_RUN;
			next_s.cpu_gate = 1'b1;
			next_s.sys_reset = 1'b1;
			next_s.mcd_cnt = 32'h0;
			next_s.pwr_flags = `EIPM_RST_PWR;
			next_s.extcfg = `EIPM_RST_EXTCFG;
			next_s.prio = 6'h00;
		end
		// ==================================================
		// External inputs: observe pins only, polarity applied
		next_s.ext0 = PORT_PIN[s.extcfg[2:0]] ~^ s.extcfg[`EIPM_BIT_E0POL];
		next_s.ext1 = PORT_PIN[s.extcfg[6:4]] ~^ s.extcfg[`EIPM_BIT_E1POL];
	end

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			s <= '0;
			s.extcfg <= `EIPM_RST_EXTCFG;
			s.cpu_gate <= 1'b1;
			s.wdt_en <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ======================================================
	// Crossbar guard and outputs
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_skip
			assign XBAR_ROUTE_OK[g] = XBAR_ROUTE_REQ[g] & ~s.skip[g];
		end
	endgenerate

	assign APB_RSP.prdata = s.prdata;
	assign APB_RSP.pslverr = s.pslverr;
	assign APB_RSP.pready = s.ack;
	assign EXTERNAL_IRQ_0 = s.ext0;
	assign EXTERNAL_IRQ_1 = s.ext1;
	assign EXT_PRIORITY = s.prio;
	// Registered gate: no combinational glitch on the enable
	assign CPU_CLK_EN = s.cpu_gate;
	assign PERIPH_CLK_EN = (s.mode != EIPM_STOP) | ~INSTR_DONE & s.cpu_gate;
	assign INT_OSC_EN = ~((s.mode == EIPM_STOP) & ~s.cpu_gate);
	assign WDT_RUN = s.wdt_en & INT_OSC_EN;
	assign SYS_RESET = s.sys_reset;
	assign RESTART_PC = `EIPM_RESTART_PC;

	// ======================================================
	// Checks
	chk_prio_ones: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		rd & (a == `EIPM_ADDR(`EIPM_IDX_PRIO)) |=> s.prdata[7:6] == 2'b11)
		else $error("priority upper bits not one");
	chk_pwr_rdzero: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		rd & (a == `EIPM_ADDR(`EIPM_IDX_PWR)) |=> s.prdata[1:0] == 2'b00)
		else $error("mode bits read nonzero");
	chk_idle_wake: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(s.mode == EIPM_IDLE) & irq_wake & ~rst_req |=> (s.mode == EIPM_RUN) & s.cpu_gate)
		else $error("idle not woken by enabled irq");
	chk_stop_hold: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(s.mode == EIPM_STOP) & ~rst_req |=> s.mode == EIPM_STOP)
		else $error("stop left without reset");
	chk_reset_run: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		rst_req |=> (s.mode == EIPM_RUN) & s.sys_reset)
		else $error("reset did not restart");
	chk_ext0_pin: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		1'b1 |=> s.ext0 == ($past(PORT_PIN[s.extcfg[2:0]]) ~^ $past(s.extcfg[3])))
		else $error("ext0 wrong pin or polarity");
	chk_skip_block: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(s.skip & XBAR_ROUTE_OK) == 8'h00)
		else $error("skipped pin routed");
	chk_idle_gate: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(s.mode == EIPM_IDLE) & INSTR_DONE & ~irq_wake & ~rst_req |=> ~CPU_CLK_EN & PERIPH_CLK_EN)
		else $error("idle did not gate cpu only");
	chk_wake_enable: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(s.mode == EIPM_IDLE) & ~GLOBAL_IRQ_ENABLE & ~rst_req |=> s.mode == EIPM_IDLE)
		else $error("woke with irqs disabled");

	chk_prio_wrlow: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		wr & (a == `EIPM_ADDR(`EIPM_IDX_PRIO)) & ~rst_req
		|=> s.prio == $past(APB_REQ.pwdata[5:0]))
		else $error("priority write lost");

	chk_prio_hold: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		~(wr & (a == `EIPM_ADDR(`EIPM_IDX_PRIO))) & ~rst_req
		|=> $stable(s.prio))
		else $error("priority changed unwritten");

	chk_ext1_pin: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		1'b1
		|=> s.ext1 == ($past(PORT_PIN[s.extcfg[6:4]]) ~^ $past(s.extcfg[7])))
		else $error("ext1 wrong pin or polarity");

	chk_cfg_write: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		wr & (a == `EIPM_ADDR(`EIPM_IDX_EXTCFG)) & ~rst_req
		|=> s.extcfg == $past(APB_REQ.pwdata[7:0]))
		else $error("config write lost");

	chk_route_pass: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		1'b1
		|-> XBAR_ROUTE_OK == (XBAR_ROUTE_REQ & ~s.skip))
		else $error("crossbar routing disturbed");

	chk_idle_enter: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		wr & (a == `EIPM_ADDR(`EIPM_IDX_PWR)) & (s.mode == EIPM_RUN)
		& APB_REQ.pwdata[0] & ~APB_REQ.pwdata[1] & ~rst_req |=> s.mode == EIPM_IDLE)
		else $error("idle not entered");

	chk_idle_cpuon: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(s.mode == EIPM_IDLE) & s.cpu_gate & ~INSTR_DONE & ~rst_req
		|=> CPU_CLK_EN)
		else $error("cpu gated before instruction end");

	chk_idle_regs: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(s.mode == EIPM_IDLE) & ~wr & ~rst_req
		|=> $stable(s.extcfg) & $stable(s.prio) & $stable(s.skip))
		else $error("register changed in idle");

	chk_idle_flags: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(s.mode == EIPM_IDLE) & ~wr & ~rst_req
		|=> $stable(s.pwr_flags))
		else $error("flags changed in idle");

	chk_status_mode: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		rd & (a == `EIPM_ADDR(`EIPM_IDX_STATUS))
		|=> s.prdata[1:0] == $past(s.mode))
		else $error("status read wrong mode");

	chk_reset_regs: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		rst_req
		|=> (s.extcfg == `EIPM_RST_EXTCFG) & (s.pwr_flags == `EIPM_RST_PWR))
		else $error("reset left registers set");

	chk_reset_pulse: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		~rst_req
		|=> ~SYS_RESET)
		else $error("reset pulse without request");

	chk_wdt_idle: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(s.mode == EIPM_IDLE) & s.wdt_en
		|-> WDT_RUN)
		else $error("watchdog stopped in idle");

	chk_wdt_reset: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		WDT_RESET_REQ
		|=> SYS_RESET & (s.mode == EIPM_RUN))
		else $error("watchdog reset ignored");

	chk_stop_enter: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		wr & (a == `EIPM_ADDR(`EIPM_IDX_PWR)) & APB_REQ.pwdata[1] & ~rst_req
		|=> s.mode == EIPM_STOP)
		else $error("stop not entered");

	chk_stop_osc: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(s.mode == EIPM_STOP) & ~s.cpu_gate
		|-> ~INT_OSC_EN & ~PERIPH_CLK_EN & ~CPU_CLK_EN)
		else $error("clocks running in stop");

	chk_stop_irq: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(s.mode == EIPM_STOP) & ~s.cpu_gate & irq_wake & ~rst_req
		|=> ~CPU_CLK_EN)
		else $error("interrupt woke stop");

	chk_mcd_count: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		s.mcd_en & OSC_CLOCK_LOST & ~rst_req
		|=> s.mcd_cnt == $past(s.mcd_cnt) + 32'h1)
		else $error("clock-loss count stalled");

	chk_mcd_clear: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		~(s.mcd_en & OSC_CLOCK_LOST)
		|=> s.mcd_cnt == 32'h0)
		else $error("clock-loss count not cleared");

	chk_mcd_fire: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		s.mcd_en & (s.mcd_cnt >= 32'(`EIPM_MCD_CYC))
		|=> SYS_RESET)
		else $error("clock-loss reset missing");

	chk_pwr_flags: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		wr & (a == `EIPM_ADDR(`EIPM_IDX_PWR)) & ~rst_req
		|=> s.pwr_flags == ($past(APB_REQ.pwdata[7:0]) & `EIPM_PWR_FLAGMASK))
		else $error("power flags write lost");

	chk_flags_read: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		rd & (a == `EIPM_ADDR(`EIPM_IDX_PWR))
		|=> s.prdata[7:2] == $past(s.pwr_flags[7:2]))
		else $error("power flags read wrong");

	chk_wake_mask: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		(s.mode == EIPM_IDLE) & ~|(IRQ_PENDING & IRQ_MASK) & ~rst_req & ~wr
		|=> s.mode == EIPM_IDLE)
		else $error("woke on masked irq");

	chk_gate_run: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		s.mode == EIPM_RUN
		|=> CPU_CLK_EN)
		else $error("cpu gated while running");

	chk_rdata_drop: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		~rd
		|=> s.prdata == 32'h0)
		else $error("read data left standing");

	chk_pready_wait: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		acc & ~s.ack
		|-> ~APB_RSP.pready)
		else $error("ready without wait state");

	chk_pready_next: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		acc & ~s.ack
		|=> APB_RSP.pready)
		else $error("ready missing after wait");

	chk_ack_drop: assert property (@(posedge CLOCK) disable iff (!RESET_N)
		s.ack
		|=> ~s.ack)
		else $error("ready held too long");
endmodule
